/* hw/crrs_core_regs.sv */
`timescale 1ns/1ps
// Contract
// - sixteen 32-bit general registers usable as data or address operands
// - register zero is the stack pointer, routed by the stack select bit
// - eight 32-bit control registers beside the general registers
// - vector table base gives the base address of every vector fetch
// - program counter holds the address of the executing instruction
// - status word holds instruction results, core state and stack select
// - fast interrupt accept copies program counter into backup counter
// - fast interrupt accept copies status word into backup status word
// - fast interrupt accept branches to the fast interrupt vector
// - 64-bit accumulator, multiply results overwrite its whole content
// - high write loads bits 63..32, low write bits 31..0, other kept
// - high read returns bits 63..32, middle read bits 47..16
// - instruction words little endian, data order selectable
module crrs_core_regs
    import crrs_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic                 gpr_wr_en,
    input  wire logic [GPR_IDX_W-1:0] gpr_wr_idx,
    input  wire logic [DATA_W-1:0]    gpr_wr_data,
    input  wire logic [GPR_IDX_W-1:0] rd_a_idx,
    input  wire logic [GPR_IDX_W-1:0] rd_b_idx,
    output logic      [DATA_W-1:0]    rd_a_data,
    output logic      [DATA_W-1:0]    rd_b_data,
    output logic      [DATA_W-1:0]    sp_out,
    input  wire logic                 cr_wr_en,
    input  wire logic [CR_IDX_W-1:0]  cr_wr_idx,
    input  wire logic [DATA_W-1:0]    cr_wr_data,
    input  wire logic [CR_IDX_W-1:0]  cr_rd_idx,
    output logic      [DATA_W-1:0]    cr_rd_data,
    input  wire logic                 pc_load,
    input  wire logic [DATA_W-1:0]    pc_next,
    output logic      [DATA_W-1:0]    pc_out,
    input  wire logic                 psw_load,
    input  wire logic [DATA_W-1:0]    psw_next,
    output logic      [DATA_W-1:0]    psw_out,
    input  wire logic                 fiq_accept,
    output logic                      fiq_branch,
    output logic      [DATA_W-1:0]    fiq_target,
    input  wire logic                 vec_req,
    input  wire logic [VEC_NUM_W-1:0] vec_num,
    output logic                      vec_valid,
    output logic      [DATA_W-1:0]    vec_addr,
    input  wire logic                 acc_load,
    input  wire logic [ACC_W-1:0]     acc_load_data,
    input  wire logic                 acc_wr_hi,
    input  wire logic                 acc_wr_lo,
    input  wire logic [DATA_W-1:0]    acc_wr_data,
    input  wire logic                 acc_rd_mid,
    output logic      [DATA_W-1:0]    acc_rd_data,
    input  wire logic                 data_big_endian,
    input  wire logic [DATA_W-1:0]    mem_rdata,
    output logic      [DATA_W-1:0]    ld_data,
    input  wire logic [DATA_W-1:0]    st_data,
    output logic      [DATA_W-1:0]    mem_wdata,
    input  wire logic [DATA_W-1:0]    fetch_word,
    output logic      [DATA_W-1:0]    instr_word
);

    crrs_state_s st_r;
    crrs_state_s st_nxt;

    localparam crrs_state_s ST_RST = '{
        gpr:         {(GPR_NUM-1){GPR_RST}},
        interrupt_stack_pointer:         CR_RST,
        user_stack_pointer:         CR_RST,
        vector_table_base:        CR_RST,
        pc:          CR_RST,
        processor_status_word:         PSW_RST,
        backup_program_counter:         CR_RST,
        backup_status_word:        PSW_RST,
        fast_irq_vector:       CR_RST,
        acc:         ACC_RST,
        rd_a_data:   GPR_RST,
        rd_b_data:   GPR_RST,
        cr_rd_data:  CR_RST,
        acc_rd_data: GPR_RST,
        sp_out:      CR_RST,
        vec_addr:    CR_RST,
        vec_valid:   1'b0,
        fiq_branch:  1'b0,
        fiq_target:  CR_RST,
        ld_data:     GPR_RST,
        mem_wdata:   GPR_RST,
        instr_word:  GPR_RST
    };

    // general register read; index zero answers with whichever stack pointer is live
    function automatic logic [DATA_W-1:0] gpr_read(input crrs_state_s s,
                                                   input logic [GPR_IDX_W-1:0] idx);
        if (idx == '0) begin
            gpr_read = s.processor_status_word[PSW_U_BIT] ? s.user_stack_pointer : s.interrupt_stack_pointer;
        end else begin
            gpr_read = s.gpr[idx];
        end
    endfunction

    // all reads but sp_out look at the registered state, so a write shows up one cycle later
    always_comb begin
        st_nxt = st_r;
        // read ports, registered answers
        st_nxt.rd_a_data = gpr_read(st_r, rd_a_idx);
        st_nxt.rd_b_data = gpr_read(st_r, rd_b_idx);
        case (cr_rd_idx)
            CR_ISP:   st_nxt.cr_rd_data = st_r.interrupt_stack_pointer;
            CR_USP:   st_nxt.cr_rd_data = st_r.user_stack_pointer;
            CR_VECTOR_TABLE_BASE:  st_nxt.cr_rd_data = st_r.vector_table_base;
            CR_PC:    st_nxt.cr_rd_data = st_r.pc;
            CR_PSW:   st_nxt.cr_rd_data = st_r.processor_status_word;
            CR_BPC:   st_nxt.cr_rd_data = st_r.backup_program_counter;
            CR_BACKUP_STATUS_WORD:  st_nxt.cr_rd_data = st_r.backup_status_word;
            CR_FAST_IRQ_VECTOR: st_nxt.cr_rd_data = st_r.fast_irq_vector;
            default:  st_nxt.cr_rd_data = CR_RST;
        endcase
        st_nxt.acc_rd_data = acc_rd_mid ? st_r.acc[ACC_MID_LSB +: DATA_W]
                                        : st_r.acc[ACC_HI_LSB +: DATA_W];

        // general register write; zero goes to the stack pointer picked by the old select bit
        if (gpr_wr_en) begin
            if (gpr_wr_idx == '0) begin
                if (st_r.processor_status_word[PSW_U_BIT]) begin
                    st_nxt.user_stack_pointer = gpr_wr_data;
                end else begin
                    st_nxt.interrupt_stack_pointer = gpr_wr_data;
                end
            end else begin
                st_nxt.gpr[gpr_wr_idx] = gpr_wr_data;
            end
        end

        // status word follows instruction results
        if (psw_load) begin
            st_nxt.processor_status_word = psw_next;
        end

        // control register write comes after the general path, so it wins on a clash
        if (cr_wr_en) begin
            case (cr_wr_idx)
                CR_ISP:   st_nxt.interrupt_stack_pointer   = cr_wr_data;
                CR_USP:   st_nxt.user_stack_pointer   = cr_wr_data;
                CR_VECTOR_TABLE_BASE:  st_nxt.vector_table_base  = cr_wr_data;
                CR_PSW:   st_nxt.processor_status_word   = cr_wr_data;
                CR_BPC:   st_nxt.backup_program_counter   = cr_wr_data;
                CR_BACKUP_STATUS_WORD:  st_nxt.backup_status_word  = cr_wr_data;
                CR_FAST_IRQ_VECTOR: st_nxt.fast_irq_vector = cr_wr_data;
                default:  st_nxt.pc    = st_r.pc; // counter moves only by pc_load or fiq_accept
            endcase
        end

        // program counter tracks the instruction in execution
        if (pc_load) begin
            st_nxt.pc = pc_next;
        end

        // fast interrupt beats every other write to the counter and backups
        st_nxt.fiq_branch = fiq_accept;
        if (fiq_accept) begin
            st_nxt.backup_program_counter        = st_r.pc;
            st_nxt.backup_status_word       = st_r.processor_status_word;
            st_nxt.pc         = st_r.fast_irq_vector;
            st_nxt.fiq_target = st_r.fast_irq_vector;
        end

        // vector address: word-sized entries from the table base
        st_nxt.vec_valid = vec_req;
        if (vec_req) begin
            st_nxt.vec_addr = st_r.vector_table_base + (DATA_W'(vec_num) << 2);
        end

        // accumulator: a full multiply result wins over the half writes
        if (acc_load) begin
            st_nxt.acc = acc_load_data;
        end else begin
            if (acc_wr_hi) begin
                st_nxt.acc[ACC_HI_LSB +: DATA_W] = acc_wr_data;
            end
            if (acc_wr_lo) begin
                st_nxt.acc[DATA_W-1:0] = acc_wr_data;
            end
        end

        // stack pointer view built from next state so the output is a plain flop
        st_nxt.sp_out = st_nxt.processor_status_word[PSW_U_BIT] ? st_nxt.user_stack_pointer : st_nxt.interrupt_stack_pointer;

        // byte order: data may swap, fetched instruction words never do
        st_nxt.ld_data    = data_big_endian ? crrs_bswap(mem_rdata) : mem_rdata;
        st_nxt.mem_wdata  = data_big_endian ? crrs_bswap(st_data) : st_data;
        st_nxt.instr_word = fetch_word;
    end

    // single state register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign rd_a_data   = st_r.rd_a_data;
    assign rd_b_data   = st_r.rd_b_data;
    assign sp_out      = st_r.sp_out;
    assign cr_rd_data  = st_r.cr_rd_data;
    assign pc_out      = st_r.pc;
    assign psw_out     = st_r.processor_status_word;
    assign fiq_branch  = st_r.fiq_branch;
    assign fiq_target  = st_r.fiq_target;
    assign vec_valid   = st_r.vec_valid;
    assign vec_addr    = st_r.vec_addr;
    assign acc_rd_data = st_r.acc_rd_data;
    assign ld_data     = st_r.ld_data;
    assign mem_wdata   = st_r.mem_wdata;
    assign instr_word  = st_r.instr_word;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    gpr_write_lands_a: assert property (
        gpr_wr_en && gpr_wr_idx != '0 ##1 rd_a_idx == $past(gpr_wr_idx)
        |=> rd_a_data == $past(gpr_wr_data, 2))
        else $error("general register write not read back");

    sp_user_route_a: assert property (
        gpr_wr_en && gpr_wr_idx == '0 && psw_out[PSW_U_BIT] && !cr_wr_en && !psw_load
        |=> sp_out == $past(gpr_wr_data))
        else $error("stack write not routed to user pointer");

    sp_select_a: assert property (
        rd_b_idx == '0 |=> rd_b_data == (psw_out[PSW_U_BIT] ? st_r.user_stack_pointer : st_r.interrupt_stack_pointer)
                           || $past(gpr_wr_en) || $past(cr_wr_en) || $past(psw_load))
        else $error("stack pointer read used wrong select");

    fiq_save_a: assert property (
        fiq_accept |=> st_r.backup_program_counter == $past(pc_out) && st_r.backup_status_word == $past(psw_out))
        else $error("fast interrupt backups not saved");

    fiq_branch_a: assert property (
        fiq_accept |=> fiq_branch && pc_out == $past(st_r.fast_irq_vector) && fiq_target == pc_out)
        else $error("fast interrupt did not branch to vector");

    vec_base_a: assert property (
        vec_req |=> vec_valid && vec_addr == $past(st_r.vector_table_base) + {$past(vec_num), 2'b00})
        else $error("vector address not from table base");

    acc_hi_keep_a: assert property (
        acc_wr_hi && !acc_wr_lo && !acc_load
        |=> st_r.acc[63:32] == $past(acc_wr_data) && st_r.acc[31:0] == $past(st_r.acc[31:0]))
        else $error("accumulator high write wrong");

    acc_mid_read_a: assert property (
        acc_load ##1 acc_rd_mid |=> acc_rd_data == $past(acc_load_data[47:16], 2))
        else $error("accumulator middle read wrong");

    pc_track_a: assert property (
        pc_load && !fiq_accept |=> pc_out == $past(pc_next))
        else $error("program counter did not load");

    endian_a: assert property (
        data_big_endian |=> ld_data == crrs_bswap($past(mem_rdata))
                            && instr_word == $past(fetch_word))
        else $error("byte order wrong");

    fiq_seen_c:  cover property (fiq_accept ##1 pc_load);
    sp_swap_c:   cover property (psw_load ##1 gpr_wr_en && gpr_wr_idx == '0);
    acc_split_c: cover property (acc_wr_hi ##1 acc_wr_lo ##1 acc_rd_mid);
    big_load_c:  cover property (data_big_endian && !$past(data_big_endian));

endmodule

/* include/crrs_pkg.sv */
package crrs_pkg;
    // data path widths
    localparam int DATA_W     = 32;
    localparam int ACC_W      = 64;
    localparam int GPR_NUM    = 16;
    localparam int GPR_IDX_W  = 4;
    localparam int CR_IDX_W   = 3;
    localparam int VEC_NUM_W  = 8;

    // control register selector codes, eight in all
    localparam logic [CR_IDX_W-1:0] CR_ISP   = 3'h0;
    localparam logic [CR_IDX_W-1:0] CR_USP   = 3'h1;
    localparam logic [CR_IDX_W-1:0] CR_VECTOR_TABLE_BASE  = 3'h2;
    localparam logic [CR_IDX_W-1:0] CR_PC    = 3'h3;
    localparam logic [CR_IDX_W-1:0] CR_PSW   = 3'h4;
    localparam logic [CR_IDX_W-1:0] CR_BPC   = 3'h5;
    localparam logic [CR_IDX_W-1:0] CR_BACKUP_STATUS_WORD  = 3'h6;
    localparam logic [CR_IDX_W-1:0] CR_FAST_IRQ_VECTOR = 3'h7;

    // stack select bit inside the status word
    localparam int PSW_U_BIT = 17;

    // accumulator field positions
    localparam int ACC_HI_LSB  = 32;
    localparam int ACC_MID_LSB = 16;

    // reset values
    localparam logic [DATA_W-1:0] GPR_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CR_RST   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PSW_RST  = 32'h0000_0000;
    localparam logic [ACC_W-1:0]  ACC_RST  = 64'h0000_0000_0000_0000;

    // whole state of the register set, outputs included
    typedef struct packed {
        logic [GPR_NUM-1:1][DATA_W-1:0] gpr;
        logic [DATA_W-1:0]              interrupt_stack_pointer;
        logic [DATA_W-1:0]              user_stack_pointer;
        logic [DATA_W-1:0]              vector_table_base;
        logic [DATA_W-1:0]              pc;
        logic [DATA_W-1:0]              processor_status_word;
        logic [DATA_W-1:0]              backup_program_counter;
        logic [DATA_W-1:0]              backup_status_word;
        logic [DATA_W-1:0]              fast_irq_vector;
        logic [ACC_W-1:0]               acc;
        logic [DATA_W-1:0]              rd_a_data;
        logic [DATA_W-1:0]              rd_b_data;
        logic [DATA_W-1:0]              cr_rd_data;
        logic [DATA_W-1:0]              acc_rd_data;
        logic [DATA_W-1:0]              sp_out;
        logic [DATA_W-1:0]              vec_addr;
        logic                           vec_valid;
        logic                           fiq_branch;
        logic [DATA_W-1:0]              fiq_target;
        logic [DATA_W-1:0]              ld_data;
        logic [DATA_W-1:0]              mem_wdata;
        logic [DATA_W-1:0]              instr_word;
    } crrs_state_s;

    // byte reversal of one word, used on both load and store paths
    function automatic logic [DATA_W-1:0] crrs_bswap(input logic [DATA_W-1:0] w);
        crrs_bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
endpackage

/* verif/crrs_mem_model.sv */
`timescale 1ns/1ps
module crrs_mem_model
    import crrs_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    output logic      [DATA_W-1:0] mem_rdata,
    output logic      [DATA_W-1:0] fetch_word
);
    logic [7:0] cnt_r;
    // new word every cycle, so a stale or reordered byte cannot pass
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    // all four bytes of mem_rdata differ, so any byte order mistake on loads is visible
    assign mem_rdata  = {cnt_r, cnt_r ^ 8'h3c, cnt_r ^ 8'hc3, ~cnt_r};
    assign fetch_word = {~cnt_r, cnt_r, 8'h5a, 8'ha5};
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import crrs_pkg::*;
    logic                 sys_clk = 1'b0;
    logic                 resetn = 1'b0;
    logic                 gpr_wr_en, cr_wr_en, pc_load, psw_load, fiq_accept, vec_req;
    logic                 acc_load, acc_wr_hi, acc_wr_lo, acc_rd_mid, data_big_endian;
    logic [GPR_IDX_W-1:0] gpr_wr_idx, rd_a_idx, rd_b_idx;
    logic [CR_IDX_W-1:0]  cr_wr_idx, cr_rd_idx;
    logic [VEC_NUM_W-1:0] vec_num;
    logic [ACC_W-1:0]     acc_load_data;
    logic [DATA_W-1:0]    gpr_wr_data, cr_wr_data, pc_next, psw_next, acc_wr_data, st_data;
    logic [DATA_W-1:0]    prev_rd, prev_fw, v;
    wire  logic [DATA_W-1:0] mem_rdata, fetch_word, rd_a_data, rd_b_data, sp_out, cr_rd_data;
    wire  logic [DATA_W-1:0] pc_out, psw_out, fiq_target, vec_addr, acc_rd_data, ld_data;
    wire  logic [DATA_W-1:0] mem_wdata, instr_word;
    wire  logic              fiq_branch, vec_valid;
    int                   num_errors = 0;
    int                   comparisons = 0;

    crrs_mem_model u_mem (.sys_clk, .resetn, .mem_rdata, .fetch_word);
    crrs_core_regs DUT (.sys_clk, .resetn, .gpr_wr_en, .gpr_wr_idx, .gpr_wr_data, .rd_a_idx,
        .rd_b_idx, .rd_a_data, .rd_b_data, .sp_out, .cr_wr_en, .cr_wr_idx, .cr_wr_data,
        .cr_rd_idx, .cr_rd_data, .pc_load, .pc_next, .pc_out, .psw_load, .psw_next, .psw_out,
        .fiq_accept, .fiq_branch, .fiq_target, .vec_req, .vec_num, .vec_valid, .vec_addr,
        .acc_load, .acc_load_data, .acc_wr_hi, .acc_wr_lo, .acc_wr_data, .acc_rd_mid,
        .acc_rd_data, .data_big_endian, .mem_rdata, .ld_data, .st_data, .mem_wdata,
        .fetch_word, .instr_word);

    always #5 sys_clk = ~sys_clk;
    // pre-edge copies of the memory side, what the registered paths must show
    always @(posedge sys_clk) begin
        prev_rd <= mem_rdata;
        prev_fw <= fetch_word;
    end

    function automatic logic [DATA_W-1:0] rev(input logic [DATA_W-1:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
    task automatic chk(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(negedge sys_clk);
    endtask
    task automatic wr_gpr(input logic [GPR_IDX_W-1:0] i, input logic [DATA_W-1:0] d);
        gpr_wr_en = 1'b1;
        gpr_wr_idx = i;
        gpr_wr_data = d;
        step();
    endtask
    task automatic wr_cr(input logic [CR_IDX_W-1:0] i, input logic [DATA_W-1:0] d);
        cr_wr_en = 1'b1;
        cr_wr_idx = i;
        cr_wr_data = d;
        step();
    endtask
    // read data issued now appears one edge later
    task automatic rd_cr(input logic [CR_IDX_W-1:0] i, output logic [DATA_W-1:0] d);
        cr_rd_idx = i;
        step();
        d = cr_rd_data;
    endtask
    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic t_gpr();
        // read the index written one cycle before, so each write but the last is read back at once
        for (int i = 1; i < GPR_NUM; i++) begin
            rd_a_idx = 4'(i - 1);
            wr_gpr(i[3:0], 32'h1000_0000 + i);
            if (i > 1) chk(rd_a_data, 32'h1000_0000 + i - 1);
        end
        gpr_wr_en = 1'h0;
        for (int i = 1; i < GPR_NUM; i++) begin
            rd_a_idx = i[3:0];
            rd_b_idx = 4'(GPR_NUM - i);
            step();
            chk(rd_a_data, 32'h1000_0000 + i);
            chk(rd_b_data, 32'h1000_0000 + GPR_NUM - i);
        end
    endtask
    // stack pointer values stay word aligned
    task automatic t_sp();
        psw_load = 1'h1;
        psw_next = 32'h0000_0000;
        step();
        psw_load = 1'h0;
        wr_gpr(4'h0, 32'h0000_2000);
        gpr_wr_en = 1'h0;
        psw_load = 1'h1;
        psw_next = 32'h0002_0000;
        step();
        psw_load = 1'h0;
        // write straight after the select flip must land in the user pointer
        wr_gpr(4'h0, 32'h0000_3000);
        gpr_wr_en = 1'h0;
        rd_a_idx = 4'h0;
        step();
        chk(psw_out, 32'h0002_0000);
        chk(rd_a_data, 32'h0000_3000);
        chk(sp_out, 32'h0000_3000);
        rd_cr(CR_ISP, v);
        chk(v, 32'h0000_2000);
        rd_cr(CR_USP, v);
        chk(v, 32'h0000_3000);
    endtask
    // data patterns keep both stack pointers word aligned
    task automatic t_cr();
        pc_load = 1'h1;
        pc_next = 32'h0000_0100;
        step();
        pc_load = 1'h0;
        for (int i = 0; i < 8; i++) wr_cr(i[2:0], 32'hc000_0000 | (i << 4));
        cr_wr_en = 1'h0;
        for (int i = 0; i < 8; i++) begin
            rd_cr(i[2:0], v);
            chk(v, (i == 3) ? 32'h0000_0100 : 32'hc000_0000 | (i << 4));
        end
        chk(pc_out, 32'h0000_0100);
    endtask
    task automatic t_vec();
        wr_cr(CR_VECTOR_TABLE_BASE, 32'h0000_4000);
        cr_wr_en = 1'h0;
        vec_req = 1'h1;
        for (int n = 0; n < 256; n += 85) begin
            vec_num = n[7:0];
            step();
            chk(vec_valid, 1'h1);
            chk(vec_addr, 32'h0000_4000 + n * 4);
        end
        vec_req = 1'h0;
        step();
        // valid follows the request one cycle later, the address holds until the next request
        chk(vec_valid, 1'h0);
        chk(vec_addr, 32'h0000_43fc);
    endtask
    task automatic t_fiq();
        pc_load = 1'h1;
        pc_next = 32'h0000_0800;
        psw_load = 1'h1;
        psw_next = 32'h0002_0005;
        wr_cr(CR_FAST_IRQ_VECTOR, 32'h0000_9000);
        {pc_load, psw_load, cr_wr_en} = 3'h0;
        fiq_accept = 1'h1;
        step();
        fiq_accept = 1'h0;
        chk(fiq_branch, 1'h1);
        chk(pc_out, 32'h0000_9000);
        chk(fiq_target, 32'h0000_9000);
        rd_cr(CR_BPC, v);
        chk(v, 32'h0000_0800);
        chk(fiq_branch, 1'h0);
        rd_cr(CR_BACKUP_STATUS_WORD, v);
        chk(v, 32'h0002_0005);
    endtask
    task automatic t_acc();
        acc_load = 1'h1;
        acc_load_data = 64'h1122_3344_5566_7788;
        step();
        // middle read right after the load, the case the design's check watches
        acc_load = 1'h0;
        acc_rd_mid = 1'h1;
        step();
        chk(acc_rd_data, 32'h3344_5566);
        acc_rd_mid = 1'h0;
        step();
        chk(acc_rd_data, 32'h1122_3344);
        acc_rd_mid = 1'h1;
        {acc_wr_hi, acc_wr_data} = {1'h1, 32'haaaa_bbbb};
        step();
        {acc_wr_hi, acc_wr_lo, acc_wr_data} = {2'h1, 32'hcccc_dddd};
        step();
        acc_wr_lo = 1'h0;
        step();
        chk(acc_rd_data, 32'hbbbb_cccc);
        acc_rd_mid = 1'h0;
        step();
        chk(acc_rd_data, 32'haaaa_bbbb);
        // a multiply result replaces all 64 bits, even against both half writes
        {acc_load, acc_wr_hi, acc_wr_lo} = 3'h7;
        acc_load_data = 64'h0f1e_2d3c_4b5a_6978;
        step();
        {acc_load, acc_wr_hi, acc_wr_lo} = 3'h0;
        step();
        chk(acc_rd_data, 32'h0f1e_2d3c);
        acc_rd_mid = 1'h1;
        step();
        chk(acc_rd_data, 32'h2d3c_4b5a);
        acc_rd_mid = 1'h0;
    endtask
    task automatic t_endian();
        for (int b = 0; b < 2; b++) begin
            data_big_endian = b[0];
            st_data = 32'h0102_0304;
            step();
            chk(ld_data, b ? rev(prev_rd) : prev_rd);
            chk(mem_wdata, b ? 32'h0403_0201 : 32'h0102_0304);
            chk(instr_word, prev_fw);
        end
    endtask

    initial begin
        {gpr_wr_en, cr_wr_en, pc_load, psw_load, fiq_accept, vec_req} = 6'h00;
        {acc_load, acc_wr_hi, acc_wr_lo, acc_rd_mid, data_big_endian} = 5'h00;
        {gpr_wr_idx, rd_a_idx, rd_b_idx, cr_wr_idx, cr_rd_idx, vec_num} = 26'h0;
        {acc_load_data, gpr_wr_data, cr_wr_data, pc_next, psw_next} = 192'h0;
        {acc_wr_data, st_data} = 64'h0;
        repeat (5) step();
        resetn = 1'b1;
        step();
        chk(pc_out, 32'h0000_0000);
        chk(acc_rd_data, 32'h0000_0000);
        t_gpr();
        t_sp();
        t_cr();
        t_vec();
        t_fiq();
        t_acc();
        t_endian();
        tally_and_finish();
    end
    // whole sequence needs about eighty cycles
    initial begin
        #(5000 * 10);
        num_errors++;
        tally_and_finish();
    end
endmodule
